/* File: design/pedc_event_disable.sv */
// pwm trigger and raw interrupt disable controls with ahb-lite registers
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pedc_consts.svh"

module pedc_event_disable #(
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [CNT_W-1:0] cnt_value,
	input wire logic cnt_down,
	input wire logic [CNT_W-1:0] compare_value_a,
	input wire logic [CNT_W-1:0] compare_value_b,
	input wire logic [CNT_W-1:0] compare_value_c,
	input wire logic [CNT_W-1:0] counter_load_value,
	output logic adc_trig,
	output logic raw_irq_cmpc_down,
	output logic irq
);

	// refuse counter widths the compares cannot serve
	generate
		if (CNT_W < `PEDC_CNT_W_MIN || CNT_W > `PEDC_CNT_W_MAX)
		begin : g_bad_cnt_w
			$error("CNT_W out of range");
		end
	endgenerate

	function automatic pedc_pkg::pedc_reg_t decode_reg(
		input logic [`PEDC_ADDR_W-1:0] a);
		if (a == `PEDC_OFF_CTRL)
			decode_reg = pedc_pkg::PEDC_REG_CTRL;
		else if (a == `PEDC_OFF_STAT)
			decode_reg = pedc_pkg::PEDC_REG_STAT;
		else if (a == `PEDC_OFF_MASK)
			decode_reg = pedc_pkg::PEDC_REG_MASK;
		else
			decode_reg = pedc_pkg::PEDC_REG_DIS;
	endfunction

	function automatic logic is_mapped(input logic [31:0] a);
		logic [`PEDC_ADDR_W-1:0] lo;
		lo = a[`PEDC_ADDR_W-1:0];
		is_mapped = (a[31:`PEDC_ADDR_W] == '0) &&
			(lo == `PEDC_OFF_CTRL || lo == `PEDC_OFF_STAT ||
			lo == `PEDC_OFF_MASK || lo == `PEDC_OFF_DIS);
	endfunction

	pedc_pkg::pedc_src_t trig_off;
	logic irq_off_cmpc_down;
	logic [`PEDC_ST_W-1:0] status;
	logic [`PEDC_ST_W-1:0] mask;
	pedc_pkg::pedc_acc_t dphase;
	pedc_pkg::pedc_acc_t aphase;
	pedc_pkg::pedc_src_t match_now;
	pedc_pkg::pedc_src_t match_q;
	pedc_pkg::pedc_src_t match_rise;
	logic cmpc_now;
	logic cmpc_q;
	logic cmpc_rise;
	logic [`PEDC_SRC_N-1:0] src_fire;
	logic [`PEDC_SRC_N-1:0] src_supp;
	logic [`PEDC_ST_W-1:0] st_set;
	logic next_trig;
	logic next_raw;
	logic ctrl_wr;
	logic stat_rd;

	// zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb
	begin
		aphase.valid = hsel && hready && htrans[1];
		aphase.write = hwrite;
		aphase.mapped = is_mapped(haddr);
		aphase.sel = decode_reg(haddr[`PEDC_ADDR_W-1:0]);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dphase <= '0;
		else
			dphase <= aphase;
	end

	assign ctrl_wr = dphase.valid && dphase.write && dphase.mapped &&
		dphase.sel == pedc_pkg::PEDC_REG_CTRL;
	assign stat_rd = aphase.valid && !aphase.write && aphase.mapped &&
		aphase.sel == pedc_pkg::PEDC_REG_STAT;

	// disables are set-only; zero bits leave them alone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			trig_off <= `PEDC_RST_DIS;
			irq_off_cmpc_down <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			trig_off <= trig_off |
				hwdata[`PEDC_TRIG_MSB:`PEDC_TRIG_LSB];
			irq_off_cmpc_down <= irq_off_cmpc_down |
				hwdata[`PEDC_IRQ_OFF_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mask <= '0;
		else if (dphase.valid && dphase.write && dphase.mapped &&
			dphase.sel == pedc_pkg::PEDC_REG_MASK)
			mask <= hwdata[`PEDC_ST_W-1:0];
	end

	// read data captured at the address phase edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= `PEDC_RST_WORD;
		else if (aphase.valid && !aphase.write && aphase.mapped)
		begin
			hrdata <= `PEDC_RST_WORD;
			case (aphase.sel)
				pedc_pkg::PEDC_REG_STAT:
					hrdata[`PEDC_ST_W-1:0] <= status;
				pedc_pkg::PEDC_REG_MASK:
					hrdata[`PEDC_ST_W-1:0] <= mask;
				pedc_pkg::PEDC_REG_DIS:
				begin
					hrdata[`PEDC_TRIG_MSB:`PEDC_TRIG_LSB] <= trig_off;
					hrdata[`PEDC_IRQ_OFF_BIT] <= irq_off_cmpc_down;
				end
				default:
					hrdata <= `PEDC_RST_WORD;
			endcase
		end
		else
			hrdata <= `PEDC_RST_WORD;
	end

	always_comb
	begin
		match_now.cmpb_down = cnt_down && cnt_value == compare_value_b;
		match_now.cmpb_up = !cnt_down && cnt_value == compare_value_b;
		match_now.cmpa_down = cnt_down && cnt_value == compare_value_a;
		match_now.cmpa_up = !cnt_down && cnt_value == compare_value_a;
		match_now.load = cnt_value == counter_load_value;
		match_now.zero = cnt_value == '0;
		cmpc_now = cnt_down && cnt_value == compare_value_c;
	end

	// one event per entry into a match
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			match_q <= '0;
			cmpc_q <= 1'b0;
		end
		else
		begin
			match_q <= match_now;
			cmpc_q <= cmpc_now;
		end
	end

	assign match_rise = match_now & ~match_q;
	assign cmpc_rise = cmpc_now && !cmpc_q;

	// each source gated only by its own disable
	generate
		for (genvar g = 0; g < `PEDC_SRC_N; g++)
		begin : g_src
			assign src_fire[g] = match_rise[g] && !trig_off[g];
			assign src_supp[g] = match_rise[g] && trig_off[g];
		end
	endgenerate

	assign next_trig = |src_fire;
	assign next_raw = cmpc_rise && !irq_off_cmpc_down;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			adc_trig <= 1'b0;
			raw_irq_cmpc_down <= 1'b0;
		end
		else
		begin
			adc_trig <= next_trig;
			raw_irq_cmpc_down <= next_raw;
		end
	end

	always_comb
	begin
		st_set = '0;
		st_set[`PEDC_ST_TRIG] = next_trig;
		st_set[`PEDC_ST_RAW] = next_raw;
		st_set[`PEDC_ST_SUPP] = |src_supp;
	end

	// read clears, a new event in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status <= '0;
		else if (stat_rd)
			status <= st_set;
		else
			status <= status | st_set;
	end

	assign irq = |(status & mask);

	default clocking pedc_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// a disabled source alone gives no trigger
	a_cmpb_down_off: assert property (
		$past(match_rise == 6'h20 && trig_off.cmpb_down) |-> !adc_trig)
		else $error("compare B down trigger not suppressed");

	a_cmpb_up_off: assert property (
		$past(match_rise == 6'h10 && trig_off.cmpb_up) |-> !adc_trig)
		else $error("compare B up trigger not suppressed");

	a_cmpa_down_off: assert property (
		$past(match_rise == 6'h08 && trig_off.cmpa_down) |-> !adc_trig)
		else $error("compare A down trigger not suppressed");

	a_cmpa_up_off: assert property (
		$past(match_rise == 6'h04 && trig_off.cmpa_up) |-> !adc_trig)
		else $error("compare A up trigger not suppressed");

	a_load_off: assert property (
		$past(match_rise == 6'h02 && trig_off.load) |-> !adc_trig)
		else $error("load match trigger not suppressed");

	a_zero_off: assert property (
		$past(match_rise == 6'h01 && trig_off.zero) |-> !adc_trig)
		else $error("zero match trigger not suppressed");

	// enabled sources keep firing
	a_cmpb_down_on: assert property (
		match_rise.cmpb_down && !trig_off.cmpb_down |=> adc_trig)
		else $error("compare B down trigger missing");

	a_cmpb_up_on: assert property (
		match_rise.cmpb_up && !trig_off.cmpb_up |=> adc_trig)
		else $error("compare B up trigger missing");

	a_cmpa_down_on: assert property (
		match_rise.cmpa_down && !trig_off.cmpa_down |=> adc_trig)
		else $error("compare A down trigger missing");

	a_cmpa_up_on: assert property (
		match_rise.cmpa_up && !trig_off.cmpa_up |=> adc_trig)
		else $error("compare A up trigger missing");

	a_load_on: assert property (
		match_rise.load && !trig_off.load |=> adc_trig)
		else $error("load match trigger missing");

	a_zero_on: assert property (
		match_rise.zero && !trig_off.zero |=> adc_trig)
		else $error("zero match trigger missing");

	a_enabled_fires: assert property (
		(match_rise & ~trig_off) != 6'h00 |=>
		adc_trig && status[`PEDC_ST_TRIG])
		else $error("enabled source did not trigger");

	// controls are set-only, cleared by reset
	a_zero_write_keeps: assert property (
		ctrl_wr && hwdata[`PEDC_TRIG_MSB:`PEDC_IRQ_OFF_BIT] == 7'h00 |=>
		$stable(trig_off) && $stable(irq_off_cmpc_down))
		else $error("writing zero changed a disable");

	a_trig_off_sticky: assert property (
		($past(trig_off) & ~trig_off) == 6'h00)
		else $error("trigger disable cleared without reset");

	a_irq_off_sticky: assert property (
		$past(irq_off_cmpc_down) |-> irq_off_cmpc_down)
		else $error("interrupt disable cleared without reset");

	a_ctrl_reads_zero: assert property (
		dphase.valid && !dphase.write && dphase.mapped &&
		dphase.sel == pedc_pkg::PEDC_REG_CTRL |->
		hrdata == `PEDC_RST_WORD)
		else $error("write-only control read back nonzero");

	// raw compare C interrupt
	a_cmpc_irq_off: assert property (
		cmpc_rise && irq_off_cmpc_down |=> !raw_irq_cmpc_down)
		else $error("raw compare C interrupt not suppressed");

	a_cmpc_irq_on: assert property (
		cmpc_rise && !irq_off_cmpc_down |=> raw_irq_cmpc_down)
		else $error("raw compare C interrupt missing");

	a_raw_one_shot: assert property (
		raw_irq_cmpc_down |=> !raw_irq_cmpc_down)
		else $error("raw compare C interrupt longer than one cycle");

	// writes land before the next match
	a_write_takes: assert property (
		ctrl_wr && hwdata[`PEDC_TRIG_MSB] |=> trig_off.cmpb_down)
		else $error("disable not applied after write");

	a_zero_off_lands: assert property (
		ctrl_wr && hwdata[`PEDC_TRIG_LSB] |=> trig_off.zero)
		else $error("zero match disable not applied after write");

	a_irq_off_lands: assert property (
		ctrl_wr && hwdata[`PEDC_IRQ_OFF_BIT] |=> irq_off_cmpc_down)
		else $error("interrupt disable not applied after write");

	c_trig_out: cover property (adc_trig);
	c_suppressed: cover property (match_rise != 6'h00 &&
		(match_rise & ~trig_off) == 6'h00);
	c_raw_irq: cover property (raw_irq_cmpc_down ##1 irq);
	c_stat_read: cover property (stat_rd && status != 3'h0);
	c_irq_blocked: cover property (cmpc_rise && irq_off_cmpc_down);

endmodule
`default_nettype wire

/* File: design/pedc_consts.svh */
// constants for the pwm event disable control block
`ifndef PEDC_CONSTS_SVH
`define PEDC_CONSTS_SVH
`define PEDC_OFF_CTRL 12'h000
`define PEDC_OFF_STAT 12'h004
`define PEDC_OFF_MASK 12'h008
`define PEDC_OFF_DIS 12'h00C
`define PEDC_ADDR_W 12
`define PEDC_TRIG_LSB 8
`define PEDC_TRIG_MSB 13
`define PEDC_IRQ_OFF_BIT 7
`define PEDC_ST_TRIG 0
`define PEDC_ST_RAW 1
`define PEDC_ST_SUPP 2
`define PEDC_ST_W 3
`define PEDC_SRC_N 6
`define PEDC_CNT_W_MIN 2
`define PEDC_CNT_W_MAX 32
`define PEDC_RST_DIS 6'h00
`define PEDC_RST_WORD 32'h0000_0000
`define PEDC_HTRANS_NONSEQ 2'h2
`define PEDC_HTRANS_SEQ 2'h3
`endif

/* File: design/pedc_pkg.sv */
// types for the pwm event disable control block
package pedc_pkg;
	// one bit per trigger source, msb first as in the control word
	typedef struct packed {
		logic cmpb_down;
		logic cmpb_up;
		logic cmpa_down;
		logic cmpa_up;
		logic load;
		logic zero;
	} pedc_src_t;

	typedef enum logic [1:0] {
		PEDC_REG_CTRL = 2'h0,
		PEDC_REG_STAT = 2'h1,
		PEDC_REG_MASK = 2'h2,
		PEDC_REG_DIS = 2'h3
	} pedc_reg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic mapped;
		pedc_reg_t sel;
	} pedc_acc_t;
endpackage

/* File: testbench/pedc_far_end.sv */
// far end model: counts trigger and raw interrupt pulses
`timescale 1ns/1ps
`default_nettype none
module pedc_far_end (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic adc_trig,
	input wire logic raw_irq,
	output logic [7:0] trig_n,
	output logic [7:0] irq_n
);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			trig_n <= 8'h00;
			irq_n <= 8'h00;
		end
		else
		begin
			trig_n <= trig_n + {7'h00, adc_trig};
			irq_n <= irq_n + {7'h00, raw_irq};
		end
	end
endmodule
`default_nettype wire

/* File: testbench/pwm_event_disable_control_tb_top.sv */
// self-checking bench for the pwm event disable block
`timescale 1ns/1ps
`default_nettype none
module pwm_event_disable_control_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [15:0] cnt_value = 16'h0005;
	logic cnt_down = 1'b0;
	logic hreadyout, hresp, adc_trig, raw_irq, irq;
	logic [31:0] hrdata, rd;
	logic [7:0] trig_n, irq_n;
	// zero, load, a up, a down, b up, b down, c down
	logic [15:0] src_val [7] = '{16'h0000, 16'h0028, 16'h000A, 16'h000A,
		16'h0014, 16'h0014, 16'h001E};
	logic src_dn [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	int error_cnt = 0;
	int n_tests = 0;
	always #2 hclk = ~hclk;
	pedc_event_disable dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cnt_value(cnt_value),
		.cnt_down(cnt_down), .compare_value_a(16'h000A),
		.compare_value_b(16'h0014), .compare_value_c(16'h001E),
		.counter_load_value(16'h0028), .adc_trig(adc_trig),
		.raw_irq_cmpc_down(raw_irq), .irq(irq));
	pedc_far_end far (.hclk(hclk), .hresetn(hresetn), .adc_trig(adc_trig),
		.raw_irq(raw_irq), .trig_n(trig_n), .irq_n(irq_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic fire(input int i, input logic [7:0] et, input logic [7:0] ei);
		logic [7:0] t0, i0;
		t0 = trig_n;
		i0 = irq_n;
		cnt_value <= src_val[i];
		cnt_down <= src_dn[i];
		@(posedge hclk);
		cnt_value <= 16'h0005;
		repeat (3) @(posedge hclk);
		chk({24'h0, trig_n - t0}, {24'h0, et});
		chk({24'h0, irq_n - i0}, {24'h0, ei});
	endtask
	task automatic t_fire_all;
		bus(1'b0, 32'hC, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 6; i++) fire(i, 8'h01, 8'h00);
		fire(6, 8'h00, 8'h01);
		$display("test fire_all done");
	endtask
	task automatic t_status;
		bus(1'b0, 32'h4, 32'h0);
		bus(1'b1, 32'h8, 32'h7);
		fire(6, 8'h00, 8'h01);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h2);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 32'h8, 32'h0);
		fire(0, 8'h01, 8'h00);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h1);
		$display("test status done");
	endtask
	task automatic t_disable;
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b1, 32'h0, 32'h100 << i);
			bus(1'b1, 32'h0, 32'h0);
			fire(i, 8'h00, 8'h00);
			for (int j = i + 1; j < 6; j++)
				fire(j, 8'h01, 8'h00);
		end
		bus(1'b0, 32'hC, 32'h0);
		chk(rd, 32'h3F00);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h5);
		$display("test disable done");
	endtask
	task automatic t_irq_off;
		bus(1'b1, 32'h0, 32'h80);
		fire(6, 8'h00, 8'h00);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		$display("test irq_off done");
	endtask
	task automatic t_reset;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'hC, 32'h0);
		chk(rd, 32'h0);
		fire(5, 8'h01, 8'h00);
		$display("test reset done");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#40000;
		error_cnt++;
		final_report();
	end
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_fire_all();
		t_status();
		t_disable();
		t_irq_off();
		t_reset();
		final_report();
	end
endmodule
`default_nettype wire
